// *** design/interval_timer_pkg.sv ***
// Shared constants, types and bus carriers for the interval timer.
// Assumes a single instruction clock and an AHB-Lite register bus.
`default_nettype none

package interval_timer_pkg;

    // ****************************************
    // Register indices and byte addresses
    // ****************************************
    localparam logic [7:0] MODE_REG_IDX = 8'hd8;   // Timer mode register
    localparam logic [7:0] COUNT_REG_IDX = 8'hd9;  // Count register
    localparam logic [7:0] STATUS_REG_IDX = 8'he0; // Sticky event status
    localparam logic [7:0] MASK_REG_IDX = 8'he1;   // Interrupt mask
    localparam int ADDR_SHIFT = 2;                 // One word per index

    // ****************************************
    // Field positions
    // ****************************************
    localparam int EN_BIT = 7;       // Count enable bit
    localparam int RATE_LSB = 4;     // Prescale select, low bit
    localparam int RATE_W = 3;       // Prescale select width
    localparam int FLAG_BIT = 0;     // Overflow flag and its mask bit

    // ****************************************
    // Values after reset and limits
    // ****************************************
    localparam int COUNT_W = 8;                       // Counter width
    localparam logic [7:0] COUNT_RST = 8'h00;         // Count reset
    localparam logic [7:0] COUNT_MAX = 8'hff;         // Wrap point
    localparam logic [2:0] RATE_RST = 3'h0;           // Divide by 256
    localparam int DIV_W = 8;                         // Prescaler width
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;      // Bus transfer
    localparam logic [31:0] RDATA_RST = 32'h00000000; // Idle read data

    // ****************************************
    // Bus phase of the register slave
    // ****************************************
    typedef enum logic [1:0] {
        BUS_IDLE,
        BUS_WRITE,
        BUS_READ_WAIT,
        BUS_READ_DONE
    } bus_phase_t;

    // AHB-Lite request toward the slave
    typedef struct packed {
        logic hsel;
        logic [31:0] haddr;
        logic [1:0] htrans;
        logic hwrite;
        logic [2:0] hsize;
        logic [31:0] hwdata;
        logic hready;
    } ahb_req_t;

    // AHB-Lite response from the slave
    typedef struct packed {
        logic hreadyout;
        logic hresp;
        logic [31:0] hrdata;
    } ahb_rsp_t;

    // Whole state of the timer block
    typedef struct packed {
        bus_phase_t phase;
        logic [31:0] addr;
        logic en;
        logic [RATE_W-1:0] rate;
        logic [COUNT_W-1:0] count;
        logic flag;
        logic irq_en;
        logic wake;
        logic [31:0] rdata;
    } timer_state_t;

    // Whole state of the prescaler
    typedef struct packed {
        logic [DIV_W-1:0] div;
        logic tick;
    } presc_state_t;

endpackage : interval_timer_pkg

`default_nettype wire

// *** design/rate_prescaler.sv ***
// Divides the instruction clock by 256 down to 2 into a tick strobe.
// Assumes the divider restarts from zero whenever counting is stopped.
`default_nettype none

module rate_prescaler #(
    parameter int DW = interval_timer_pkg::DIV_W
) (
    input wire logic i_clock,
    input wire logic i_resetn,
    input wire logic i_run,
    input wire logic [interval_timer_pkg::RATE_W-1:0] i_rate,
    output logic o_tick
);
    import interval_timer_pkg::*;

    presc_state_t st_ff;  // Registered state
    presc_state_t nxt_st; // Next state
    logic [DW-1:0] mask;  // Low divider bits that must be all ones

    // ****************************************
    // Divider and tick
    // ****************************************
    // Code 0 looks at all bits (256), code 7 at one bit (2)
    always_comb begin
        mask = {DW{1'b1}} >> i_rate;
        nxt_st = st_ff;
        if (i_run) begin
            nxt_st.div = st_ff.div + 1'b1;
            nxt_st.tick = (st_ff.div & mask) == mask; // see (RL4)
        end else begin
            // Stopped: restart phase so the first tick is a full period
            nxt_st.div = '0;
            nxt_st.tick = 1'b0;
        end
    end

    // State register
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign o_tick = st_ff.tick;

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_resetn);

    property p_rate_two;
        (o_tick && i_run && i_rate == 3'h7) ##1 (i_run && i_rate == 3'h7)
            |-> !o_tick ##1 (i_run && i_rate == 3'h7) |-> o_tick;
    endproperty
    a_rate_two: assert property (p_rate_two) else $error("fastest rate not two cycles"); // see (RL4)

endmodule : rate_prescaler

`default_nettype wire

// *** design/eight_bit_interval_timer.sv ***
// Eight-bit interval timer with an AHB-Lite register slave.
// Assumes i_clock is the instruction clock and all inputs are synchronous.
`default_nettype none

// Functional notes
// (RL1) Eight-bit counter adds one per selected tick
// (RL2) Wrap to zero continues, raises interrupt request
// (RL3) Mode bit seven enables counting, resets zero
// (RL4) Rate code selects divide 256 down to 2
// (RL5) Count register readable, writable, resets zero
// (RL6) Software preloads 256 minus interval times rate
// (RL7) Overflow wakes system from green mode
// (RL8) Software follows the documented setup order
// (RL9) Flag sets even with interrupt disabled
// (RL10) Disabled counter holds, later resumes same value
module eight_bit_interval_timer (
    input wire logic i_clock,
    input wire logic i_resetn,
    input wire interval_timer_pkg::ahb_req_t i_ahb,
    output interval_timer_pkg::ahb_rsp_t o_ahb,
    input wire logic i_green_mode,
    output logic o_irq,
    output logic o_wakeup
);
    import interval_timer_pkg::*;

    // ****************************************
    // Declarations
    // ****************************************
    timer_state_t st_ff;  // Registered state
    timer_state_t nxt_st; // Next state
    logic tick;           // Prescaled count strobe
    logic take;           // Address phase accepted
    logic wr_mode;        // Mode register written now
    logic wr_count;       // Count register written now
    logic wr_status;      // Status register written now
    logic wr_mask;        // Mask register written now
    logic ovf;            // Counter wraps this cycle
    logic [7:0] rd_val;   // Value for the captured read address

    // Matches a bus address to a register index
    function automatic logic reg_at(
        input logic [31:0] addr,
        input logic [7:0] idx
    );
        reg_at = addr == (32'(idx) << ADDR_SHIFT);
    endfunction

    // ****************************************
    // Prescaler
    // ****************************************
    // Runs only while counting is enabled
    rate_prescaler #(
        .DW(DIV_W)
    ) u_prescaler (
        .i_clock(i_clock),
        .i_resetn(i_resetn),
        .i_run(st_ff.en),
        .i_rate(st_ff.rate),
        .o_tick(tick)
    );

    // ****************************************
    // Bus decode
    // ****************************************
    // Write strobes act in the data phase of a write
    always_comb begin
        take = i_ahb.hsel && i_ahb.hready && (i_ahb.htrans == HTRANS_NONSEQ);
        wr_mode = 1'b0;
        wr_count = 1'b0;
        wr_status = 1'b0;
        wr_mask = 1'b0;
        if (st_ff.phase == BUS_WRITE) begin
            wr_mode = reg_at(st_ff.addr, MODE_REG_IDX);
            wr_count = reg_at(st_ff.addr, COUNT_REG_IDX);
            wr_status = reg_at(st_ff.addr, STATUS_REG_IDX);
            wr_mask = reg_at(st_ff.addr, MASK_REG_IDX);
        end
    end

    // Read multiplexer; unmapped addresses read zero
    always_comb begin
        rd_val = 8'h00;
        if (reg_at(st_ff.addr, MODE_REG_IDX)) begin
            rd_val[EN_BIT] = st_ff.en;
            rd_val[RATE_LSB +: RATE_W] = st_ff.rate;
        end else if (reg_at(st_ff.addr, COUNT_REG_IDX)) begin
            rd_val = st_ff.count; // see (RL5)
        end else if (reg_at(st_ff.addr, STATUS_REG_IDX)) begin
            rd_val[FLAG_BIT] = st_ff.flag;
        end else if (reg_at(st_ff.addr, MASK_REG_IDX)) begin
            rd_val[FLAG_BIT] = st_ff.irq_en;
        end
    end

    // ****************************************
    // Counter and overflow
    // ****************************************
    // A count write in the same cycle beats the tick
    assign ovf = tick && st_ff.en && !wr_count
        && (st_ff.count == COUNT_MAX); // see (RL2)

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        nxt_st = st_ff;
        // Bus phase sequencing
        unique case (st_ff.phase)
            BUS_READ_WAIT: begin
                // Wait state: capture the read data
                nxt_st.rdata = {24'h000000, rd_val};
                nxt_st.phase = BUS_READ_DONE;
            end
            BUS_IDLE, BUS_WRITE, BUS_READ_DONE: begin
                // Ready: a new address phase may start
                if (take) begin
                    nxt_st.addr = i_ahb.haddr;
                    nxt_st.phase = i_ahb.hwrite ? BUS_WRITE : BUS_READ_WAIT;
                end else begin
                    nxt_st.phase = BUS_IDLE;
                end
            end
        endcase

        // Mode register: enable and prescale select
        if (wr_mode) begin
            nxt_st.en = i_ahb.hwdata[EN_BIT]; // see (RL3)
            nxt_st.rate = i_ahb.hwdata[RATE_LSB +: RATE_W]; // see (RL4)
        end

        // Counter: load, count, or hold
        if (wr_count) begin
            nxt_st.count = i_ahb.hwdata[COUNT_W-1:0]; // see (RL5)
        end else if (tick && st_ff.en) begin
            // Wraps from max to zero and keeps going
            nxt_st.count = st_ff.count + 1'b1; // see (RL1) (RL2)
        end else begin
            nxt_st.count = st_ff.count; // see (RL10)
        end

        // Sticky flag: overflow wins over a write-one clear
        if (ovf) begin
            nxt_st.flag = 1'b1; // see (RL9)
        end else if (wr_status && i_ahb.hwdata[FLAG_BIT]) begin
            nxt_st.flag = 1'b0;
        end

        // Interrupt mask
        if (wr_mask) begin
            nxt_st.irq_en = i_ahb.hwdata[FLAG_BIT];
        end

        // Wake pulse on overflow in green mode
        nxt_st.wake = ovf && i_green_mode; // see (RL7)
    end

    // ****************************************
    // State register
    // ****************************************
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            st_ff.phase <= BUS_IDLE;
            st_ff.addr <= 32'h00000000;
            st_ff.en <= 1'b0;
            st_ff.rate <= RATE_RST;
            st_ff.count <= COUNT_RST;
            st_ff.flag <= 1'b0;
            st_ff.irq_en <= 1'b0;
            st_ff.wake <= 1'b0;
            st_ff.rdata <= RDATA_RST;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    // Only read data waits one cycle; response is always OKAY
    always_comb begin
        o_ahb.hreadyout = st_ff.phase != BUS_READ_WAIT;
        o_ahb.hresp = 1'b0;
        o_ahb.hrdata = st_ff.rdata;
    end

    // Flag reaches the interrupt line only when unmasked
    assign o_irq = st_ff.flag && st_ff.irq_en; // see (RL9)
    assign o_wakeup = st_ff.wake;

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_resetn);

    // ****************************************
    // Checks on the counter and prescaler
    // ****************************************
    // A tick below the top adds exactly one
    property p_count_step;
        (tick && st_ff.en && !wr_count && st_ff.count != COUNT_MAX)
            |=> st_ff.count == $past(st_ff.count) + 8'h01;
    endproperty
    a_count_step: assert property (p_count_step) else $error("count did not step by one"); // see (RL1)

    // Between ticks the running count stands still
    property p_count_idle;
        (st_ff.en && !tick && !wr_count) |=> $stable(st_ff.count);
    endproperty
    a_count_idle: assert property (p_count_idle) else $error("count moved without a tick"); // see (RL1)

    // The top wraps to zero and raises the flag; no tick follows at once
    property p_wrap;
        (tick && st_ff.en && !wr_count && st_ff.count == COUNT_MAX)
            |=> (st_ff.count == 8'h00) && st_ff.flag ##1 (st_ff.count == 8'h00 || $past(wr_count));
    endproperty
    a_wrap: assert property (p_wrap) else $error("wrap did not clear count and set flag"); // see (RL2)

    // Nothing but an overflow raises the flag
    property p_flag_source;
        (!st_ff.flag && !ovf) |=> !st_ff.flag;
    endproperty
    a_flag_source: assert property (p_flag_source) else $error("flag rose without overflow"); // see (RL2)

    // A stopped timer makes no tick and no wake pulse
    property p_enable_gate;
        !st_ff.en |=> !tick && !o_wakeup;
    endproperty
    a_enable_gate: assert property (p_enable_gate) else $error("counting while disabled"); // see (RL3)

    // A mode write lands in the enable and rate fields together
    property p_mode_write;
        wr_mode |=> st_ff.en == $past(i_ahb.hwdata[EN_BIT])
            && st_ff.rate == $past(i_ahb.hwdata[RATE_LSB +: RATE_W]);
    endproperty
    a_mode_write: assert property (p_mode_write) else $error("mode write not taken"); // see (RL3) (RL4)

    // At rate seven a tick comes every second cycle
    property p_rate_div2;
        (st_ff.en && st_ff.rate == 3'h7 && tick) ##1 (st_ff.en && st_ff.rate == 3'h7)
            ##1 (st_ff.en && st_ff.rate == 3'h7) |-> tick;
    endproperty
    a_rate_div2: assert property (p_rate_div2) else $error("rate seven tick not every two cycles"); // see (RL4)

    // Ticks are never back to back, whatever the rate
    property p_tick_gap;
        tick |=> !tick;
    endproperty
    a_tick_gap: assert property (p_tick_gap) else $error("two ticks in a row"); // see (RL4)

    // A disabled counter keeps its value
    property p_hold;
        (!st_ff.en && !wr_count) [*2] |-> $stable(st_ff.count);
    endproperty
    a_hold: assert property (p_hold) else $error("disabled counter changed"); // see (RL10)

    // ****************************************
    // Checks on the bus, flag and wake
    // ****************************************
    // A count write loads the bus data
    property p_count_load;
        wr_count |=> st_ff.count == $past(i_ahb.hwdata[7:0]);
    endproperty
    a_count_load: assert property (p_count_load) else $error("count write not loaded"); // see (RL5)

    // A count write beats a tick, so it never raises the flag
    property p_load_no_wrap;
        (wr_count && !st_ff.flag) |=> !st_ff.flag;
    endproperty
    a_load_no_wrap: assert property (p_load_no_wrap) else $error("count write raised the flag"); // see (RL5)

    // A read waits one cycle before its data stands
    property p_read_wait;
        (take && !i_ahb.hwrite && o_ahb.hreadyout) |=> !o_ahb.hreadyout ##1 o_ahb.hreadyout;
    endproperty
    a_read_wait: assert property (p_read_wait) else $error("read wait state wrong"); // see (RL5)

    // A write completes with no wait state
    property p_write_ready;
        (take && i_ahb.hwrite && o_ahb.hreadyout) |=> o_ahb.hreadyout;
    endproperty
    a_write_ready: assert property (p_write_ready) else $error("write data phase stalled"); // see (RL5)

    // Overflow in green mode gives a single wake pulse
    property p_wake;
        (ovf && i_green_mode) |=> o_wakeup ##1 !o_wakeup;
    endproperty
    a_wake: assert property (p_wake) else $error("no wake pulse after overflow"); // see (RL7)

    // Overflow sets the flag; the line follows the mask
    property p_flag_masked;
        ovf |=> st_ff.flag && (o_irq == st_ff.irq_en);
    endproperty
    a_flag_masked: assert property (p_flag_masked) else $error("flag or irq wrong after overflow"); // see (RL9)

    // The flag stays until software writes the status word
    property p_flag_sticky;
        (st_ff.flag && !wr_status) |=> st_ff.flag;
    endproperty
    a_flag_sticky: assert property (p_flag_sticky) else $error("flag dropped by itself"); // see (RL9)

    // Writing a one clears the flag when no overflow competes
    property p_flag_clear;
        (wr_status && i_ahb.hwdata[FLAG_BIT] && !ovf) |=> !st_ff.flag;
    endproperty
    a_flag_clear: assert property (p_flag_clear) else $error("flag not cleared by write"); // see (RL9)

    // Unmasking a pending flag raises the interrupt line
    property p_irq_unmask;
        (wr_mask && i_ahb.hwdata[FLAG_BIT] && st_ff.flag && !wr_status) |=> o_irq;
    endproperty
    a_irq_unmask: assert property (p_irq_unmask) else $error("pending flag not seen after unmask"); // see (RL9)

endmodule : eight_bit_interval_timer

`default_nettype wire

// *** verif/testbench.sv ***
// Self-checking bench for the eight-bit interval timer.
// Assumes the design package is compiled first and the block is the only AHB-Lite slave.
`default_nettype none

module testbench import interval_timer_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;

    // ****************************************
    // Signals, addresses and counters
    // ****************************************
    localparam logic [31:0] A_MODE = 32'(MODE_REG_IDX) << ADDR_SHIFT;   // Mode word
    localparam logic [31:0] A_COUNT = 32'(COUNT_REG_IDX) << ADDR_SHIFT; // Count word
    localparam logic [31:0] A_STAT = 32'(STATUS_REG_IDX) << ADDR_SHIFT; // Status word
    localparam logic [31:0] A_MASK = 32'(MASK_REG_IDX) << ADDR_SHIFT;   // Mask word
    localparam logic [31:0] A_FREE = 32'h00000388;                      // Unmapped word
    localparam logic [31:0] EN = 32'h1 << EN_BIT;                       // Enable bit
    localparam int LIMIT = 20000;                                       // Hang ceiling
    logic i_clock;         // Instruction clock
    logic i_resetn;        // Reset, active low
    logic i_green_mode;    // Low-power mode level
    logic o_irq;           // Interrupt level
    logic o_wakeup;        // Wake pulse
    ahb_req_t req;         // Master side of the bus
    ahb_req_t bus;         // Request with hready looped back
    ahb_rsp_t rsp;         // Slave answer
    int n_fail = 0;        // Mismatches
    int n_tests = 0;       // Comparisons
    int cycles = 0;        // Clock cycles since start
    logic [31:0] v;        // Read data

    eight_bit_interval_timer dut_u (
        .i_clock(i_clock),
        .i_resetn(i_resetn),
        .i_ahb(bus),
        .o_ahb(rsp),
        .i_green_mode(i_green_mode),
        .o_irq(o_irq),
        .o_wakeup(o_wakeup)
    );

    // The single slave's hreadyout is the bus hready
    always_comb begin
        bus = req;
        bus.hready = rsp.hreadyout;
    end

    // Clock of 40 ns period
    always #20 i_clock = ~i_clock;

    // Cuts a hang short
    always @(posedge i_clock) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            n_fail++;
            tally_and_finish();
        end
    end

    // ****************************************
    // Bus tasks and comparison
    // ****************************************
    // Single word write: address phase, then data phase
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        @(posedge i_clock);
        req.htrans <= HTRANS_NONSEQ;
        req.haddr <= a;
        req.hwrite <= 1'b1;
        do @(posedge i_clock); while (rsp.hreadyout !== 1'b1);
        req.htrans <= 2'h0;
        req.hwdata <= d;
        do @(posedge i_clock); while (rsp.hreadyout !== 1'b1);
    endtask

    // Single word read; data taken at the edge that ends the data phase
    task automatic rd(input logic [31:0] a, output logic [31:0] d);
        @(posedge i_clock);
        req.htrans <= HTRANS_NONSEQ;
        req.haddr <= a;
        req.hwrite <= 1'b0;
        do @(posedge i_clock); while (rsp.hreadyout !== 1'b1);
        req.htrans <= 2'h0;
        do @(posedge i_clock); while (rsp.hreadyout !== 1'b1);
        d = rsp.hrdata;
    endtask

    // Counts and reports one comparison
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Verdict and end of run
    task automatic tally_and_finish();
        if (n_fail == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    // Values after reset, unmapped word, field readback
    task automatic t_regs();
        rd(A_MODE, v); check(v, 32'h0);
        rd(A_COUNT, v); check(v, 32'h0);
        rd(A_STAT, v); check(v, 32'h0);
        rd(A_MASK, v); check(v, 32'h0);
        wr(A_FREE, 32'hffffffff);
        rd(A_FREE, v); check(v, 32'h0);
        wr(A_COUNT, 32'h0000015a);
        rd(A_COUNT, v); check(v, 32'h5a);
        wr(A_MODE, 32'h0000007f);
        rd(A_MODE, v); check(v, 32'h70);
        rd(A_COUNT, v); check(v, 32'h5a);
    endtask

    // Every rate code: four ticks of the chosen divider, then hold
    task automatic t_rates();
        int d;
        logic [31:0] m;
        for (int r = 0; r < 8; r++) begin
            d = 256 >> r;
            m = 32'(r) << RATE_LSB;
            wr(A_COUNT, 32'h0);
            wr(A_MODE, m | EN);
            repeat (4 * d - 1) @(posedge i_clock);
            wr(A_MODE, m);
            rd(A_COUNT, v); check(v, 32'h4);
            repeat (9) @(posedge i_clock);
            rd(A_COUNT, v); check(v, 32'h4);
        end
        // Resume from the held value at the fastest rate
        wr(A_MODE, 32'h70 | EN);
        repeat (7) @(posedge i_clock);
        wr(A_MODE, 32'h70);
        rd(A_COUNT, v); check(v, 32'h8);
    endtask

    // Wrap past the top, flag, wake pulse, interrupt mask and clear
    task automatic t_overflow();
        int n;
        wr(A_STAT, 32'h1);
        wr(A_MASK, 32'h0);
        i_green_mode <= 1'b1;
        wr(A_COUNT, 32'hfe);
        wr(A_MODE, 32'h50 | EN);
        n = 0;
        do begin
            @(posedge i_clock);
            n++;
        end while (o_wakeup !== 1'b1 && n < 40);
        check(32'(n < 40), 32'h1);
        check(32'(o_irq), 32'h0);
        @(posedge i_clock);
        check(32'(o_wakeup), 32'h0);
        repeat (9) @(posedge i_clock);
        wr(A_MODE, 32'h50);
        i_green_mode <= 1'b0;
        rd(A_COUNT, v); check(v, 32'h1);
        rd(A_STAT, v); check(v, 32'h1);
        wr(A_MASK, 32'h1);
        #1 check(32'(o_irq), 32'h1);
        wr(A_STAT, 32'h1);
        #1 check(32'(o_irq), 32'h0);
        rd(A_STAT, v); check(v, 32'h0);
    endtask

    // Setup in the required order; five ticks preloaded as 256 minus five
    task automatic t_interval();
        int n;
        logic w;
        wr(A_MODE, 32'h0);
        wr(A_MASK, 32'h0);
        wr(A_STAT, 32'h1);
        wr(A_MODE, 32'h70);
        wr(A_COUNT, 32'(256 - 5));
        wr(A_MASK, 32'h1);
        wr(A_MODE, 32'h70 | EN);
        n = 0;
        w = 1'b0;
        do begin
            @(posedge i_clock);
            n++;
            w = w | o_wakeup;
        end while (o_irq !== 1'b1 && n < 40);
        check(32'(n), 32'hc);
        check(32'(w), 32'h0);
    endtask

    // Reset in mid-run: running timer and raised interrupt return to idle
    task automatic t_reset();
        @(posedge i_clock);
        i_resetn <= 1'b0;
        repeat (3) @(posedge i_clock);
        check(32'(o_irq), 32'h0);
        check(rsp.hrdata, 32'h0);
        i_resetn <= 1'b1;
        t_regs();
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        i_clock = 1'b0;
        i_resetn = 1'b0;
        i_green_mode = 1'b0;
        req = '0;
        req.hsel = 1'b1;
        req.hsize = 3'h2;
        repeat (3) @(posedge i_clock);
        i_resetn <= 1'b1;
        t_regs();
        t_rates();
        t_overflow();
        t_interval();
        t_reset();
        tally_and_finish();
    end
endmodule // testbench

`default_nettype wire
